// ===== src/meog_defs.svh
`ifndef MEOG_DEFS_SVH
`define MEOG_DEFS_SVH
`define MEOG_W 16
`define MEOG_XW 18
`define MEOG_PW 36
`define MEOG_CW 16
`define MEOG_NCH 60
`define MEOG_SELW 6
`define MEOG_FULL 16'hFFFF
`define MEOG_ZERO 16'h0000
`define MEOG_CLK_NS 25
`define MEOG_TICK_US 1000
`define MEOG_NS_PER_US 1000
`define MEOG_TICK_CYC (`MEOG_TICK_US * `MEOG_NS_PER_US / `MEOG_CLK_NS)
`endif

// ===== src/meog_pkg.sv
package meog_pkg;
	// Relay operating selection
	typedef enum logic [2:0] {
		MEOG_RM_DIS = 3'h0,
		MEOG_RM_ABOVE = 3'h1,
		MEOG_RM_BELOW = 3'h2,
		MEOG_RM_INSIDE = 3'h3,
		MEOG_RM_OUTSIDE = 3'h4
	} meog_rmode_e;
	// Reaction to a source alarm
	typedef enum logic [2:0] {
		MEOG_AM_HOLD = 3'h0,
		MEOG_AM_IMM_OFF = 3'h1,
		MEOG_AM_IMM_ON = 3'h2,
		MEOG_AM_TIM_OFF = 3'h3,
		MEOG_AM_TIM_ON = 3'h4
	} meog_amode_e;
	// Relay sequencer, Gray order low-rise-high-fall
	typedef enum logic [1:0] {
		MEOG_ST_LOW = 2'b00,
		MEOG_ST_RISE = 2'b01,
		MEOG_ST_HIGH = 2'b11,
		MEOG_ST_FALL = 2'b10
	} meog_st_e;
endpackage

// ===== src/meog_top.sv
`include "meog_defs.svh"

//Contract
// - Relay type drives only zero or full scale 65535.
// - Active output with relay selection disabled sends zero.
// - Above mode: high while source exceeds threshold, else low.
// - Below mode: high while source is under threshold, else low.
// - Inside mode: high while source lies between window bounds.
// - Outside mode: high while source lies beyond window bounds.
// - Switching points are threshold plus and minus hysteresis margin.
// - Alarm when source reports error, below range or above range.
// - Hold reaction leaves relay unchanged during the alarm.
// - Immediate reaction forces relay low or high at once.
// - Timed-off reaction drives low after the switching delay.
// - On-delay passes after condition is met before going high.
// - Off-delay passes after condition ends before going low.
// - High state lasts at least the minimum high time.
// - Low state lasts at least the minimum low time.
// - Source picked from 60 logical channels.
// - Linear type clamps source to input bounds first.
// - Linear map sends input bounds onto output bounds.
// - Linear result clamped to output bounds.
// - Linear type sends alarm value while source is in alarm.
// - Undefined source or all-zero bounds give zero.
module meog_top
	import meog_pkg::*;
#(
	parameter int TICK_CYC = `MEOG_TICK_CYC
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Logical channels
	input wire logic signed [`MEOG_W-1:0] chan_value [0:`MEOG_NCH-1],
	input wire logic [`MEOG_NCH-1:0] chan_defined,
	input wire logic [`MEOG_NCH-1:0] chan_error,
	input wire logic [`MEOG_NCH-1:0] below_range_flag,
	input wire logic [`MEOG_NCH-1:0] above_range_flag,
	// Output setup
	input wire logic out_active,
	input wire logic ctrl_linear,
	input wire logic [`MEOG_SELW-1:0] src_sel,
	// Relay setup
	input meog_rmode_e relay_mode,
	input meog_amode_e alarm_mode,
	input wire logic signed [`MEOG_W-1:0] level,
	input wire logic signed [`MEOG_W-1:0] win_lower,
	input wire logic signed [`MEOG_W-1:0] win_upper,
	input wire logic signed [`MEOG_W-1:0] hyst,
	input wire logic [`MEOG_CW-1:0] on_delay,
	input wire logic [`MEOG_CW-1:0] off_delay,
	input wire logic [`MEOG_CW-1:0] min_on,
	input wire logic [`MEOG_CW-1:0] min_off,
	// Linear setup
	input wire logic signed [`MEOG_W-1:0] in_lo,
	input wire logic signed [`MEOG_W-1:0] in_hi,
	input wire logic [`MEOG_W-1:0] out_lo,
	input wire logic [`MEOG_W-1:0] out_hi,
	input wire logic [`MEOG_W-1:0] lin_alarm,
	// Result
	output logic [`MEOG_W-1:0] out_value,
	output logic relay_high
);

	function automatic logic signed [`MEOG_XW-1:0] ext(input logic signed [`MEOG_W-1:0] v);
		return `MEOG_XW'(v);
	endfunction

	logic sel_ok;
	logic src_def;
	logic alarm;
	logic signed [`MEOG_W-1:0] src;
	logic signed [`MEOG_XW-1:0] x;
	logic signed [`MEOG_XW-1:0] lvl_up;
	logic signed [`MEOG_XW-1:0] lvl_dn;
	logic signed [`MEOG_XW-1:0] wl_up;
	logic signed [`MEOG_XW-1:0] wl_dn;
	logic signed [`MEOG_XW-1:0] wu_up;
	logic signed [`MEOG_XW-1:0] wu_dn;
	logic cond;
	logic rly_on;
	logic next_on;
	logic relay_run;
	logic hold;
	logic imm_on;
	logic imm_off;
	logic want;
	logic tick;
	logic dly_done;
	logic min_done;
	logic [`MEOG_CW-1:0] tick_cnt;
	logic [`MEOG_CW-1:0] delay_cnt;
	logic [`MEOG_CW-1:0] hold_cnt;
	meog_st_e state;
	meog_st_e next_state;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Channel selection and alarm flags
	assign sel_ok = src_sel < `MEOG_SELW'(`MEOG_NCH);
	always_comb
	begin
		src = '0;
		src_def = 1'b0;
		alarm = 1'b0;
		if (sel_ok)
		begin
			src = chan_value[src_sel];
			src_def = chan_defined[src_sel];
			alarm = chan_error[src_sel] | below_range_flag[src_sel]
				| above_range_flag[src_sel];
		end
	end

	// Switching points with hysteresis
	assign x = ext(src);
	assign lvl_up = ext(level) + ext(hyst);
	assign lvl_dn = ext(level) - ext(hyst);
	assign wl_up = ext(win_lower) + ext(hyst);
	assign wl_dn = ext(win_lower) - ext(hyst);
	assign wu_up = ext(win_upper) + ext(hyst);
	assign wu_dn = ext(win_upper) - ext(hyst);
	assign rly_on = (state == MEOG_ST_HIGH) || (state == MEOG_ST_FALL);

	// Comparator, wider band once high
	always_comb
	begin
		cond = 1'b0;
		unique case (relay_mode)
			MEOG_RM_ABOVE: cond = rly_on ? (x > lvl_dn) : (x > lvl_up);
			MEOG_RM_BELOW: cond = rly_on ? (x < lvl_up) : (x < lvl_dn);
			MEOG_RM_INSIDE: cond = rly_on ? (x > wl_dn && x < wu_up)
				: (x > wl_up && x < wu_dn);
			MEOG_RM_OUTSIDE: cond = rly_on ? (x < wl_up || x > wu_dn)
				: (x < wl_dn || x > wu_up);
			default: cond = 1'b0;
		endcase
	end

	// Alarm reaction
	assign relay_run = out_active && !ctrl_linear && (relay_mode != MEOG_RM_DIS);
	assign hold = alarm && (alarm_mode == MEOG_AM_HOLD);
	assign imm_on = alarm && (alarm_mode == MEOG_AM_IMM_ON);
	assign imm_off = alarm && (alarm_mode == MEOG_AM_IMM_OFF);
	// Timed reactions steer the normal delayed path
	assign want = alarm ? (alarm_mode == MEOG_AM_TIM_ON) : cond;

	// Millisecond tick divider
	assign tick = tick_cnt == `MEOG_CW'(TICK_CYC - 1);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tick_cnt <= '0;
		else if (tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + `MEOG_CW'(1);
	end

	// Delay and minimum-time checks
	assign dly_done = delay_cnt >= ((state == MEOG_ST_RISE) ? on_delay : off_delay);
	assign min_done = hold_cnt >= ((state == MEOG_ST_RISE) ? min_off : min_on);

	// Next relay state
	always_comb
	begin
		next_state = state;
		if (!relay_run)
			next_state = MEOG_ST_LOW;
		else if (imm_on)
			next_state = MEOG_ST_HIGH;
		else if (imm_off)
			next_state = MEOG_ST_LOW;
		else if (!hold)
		begin
			unique case (state)
				MEOG_ST_LOW:
					if (want)
						next_state = MEOG_ST_RISE;
				MEOG_ST_RISE:
					if (!want)
						next_state = MEOG_ST_LOW;
					else if (dly_done && min_done)
						next_state = MEOG_ST_HIGH;
				MEOG_ST_HIGH:
					if (!want)
						next_state = MEOG_ST_FALL;
				MEOG_ST_FALL:
					if (want)
						next_state = MEOG_ST_HIGH;
					else if (dly_done && min_done)
						next_state = MEOG_ST_LOW;
			endcase
		end
	end
	assign next_on = (next_state == MEOG_ST_HIGH) || (next_state == MEOG_ST_FALL);

	// Relay state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= MEOG_ST_LOW;
		else
			state <= next_state;
	end

	// Switching delay counter, restarts on each state change
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			delay_cnt <= '0;
		else if (next_state != state)
			delay_cnt <= '0;
		else if (tick && !hold && delay_cnt != '1)
			delay_cnt <= delay_cnt + `MEOG_CW'(1);
	end

	// Time spent at the present output level
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hold_cnt <= '0;
		else if (next_on != rly_on)
			hold_cnt <= '0;
		else if (tick && !hold && hold_cnt != '1)
			hold_cnt <= hold_cnt + `MEOG_CW'(1);
	end

	logic signed [`MEOG_W-1:0] xc;
	logic signed [`MEOG_XW-1:0] dx;
	logic signed [`MEOG_XW-1:0] dy;
	logic signed [`MEOG_XW-1:0] den;
	logic signed [`MEOG_XW-1:0] olo;
	logic signed [`MEOG_XW-1:0] ohi;
	logic signed [`MEOG_XW-1:0] omin;
	logic signed [`MEOG_XW-1:0] omax;
	logic signed [`MEOG_PW-1:0] prod;
	logic signed [`MEOG_PW-1:0] quo;
	logic signed [`MEOG_PW-1:0] ysum;
	logic [`MEOG_W-1:0] ymap;
	logic lin_zero;
	logic [`MEOG_W-1:0] next_out;

	// Input clamp
	assign xc = (src < in_lo) ? in_lo : ((src > in_hi) ? in_hi : src);

	// Linear transfer
	assign olo = $signed({2'b00, out_lo});
	assign ohi = $signed({2'b00, out_hi});
	assign dx = ext(xc) - ext(in_lo);
	assign dy = ohi - olo;
	assign den = ext(in_hi) - ext(in_lo);
	assign prod = `MEOG_PW'(dx) * `MEOG_PW'(dy);
	assign quo = (den == '0) ? '0 : prod / `MEOG_PW'(den);
	assign ysum = `MEOG_PW'(olo) + quo;

	// Output clamp
	assign omin = (olo < ohi) ? olo : ohi;
	assign omax = (olo < ohi) ? ohi : olo;
	assign ymap = (ysum < `MEOG_PW'(omin)) ? out_lo < out_hi ? out_lo : out_hi
		: (ysum > `MEOG_PW'(omax)) ? (out_lo < out_hi ? out_hi : out_lo)
		: ysum[`MEOG_W-1:0];
	assign lin_zero = !src_def || (in_lo == '0 && in_hi == '0
		&& out_lo == '0 && out_hi == '0);

	// Value sent to the slave
	always_comb
	begin
		next_out = `MEOG_ZERO;
		if (!out_active)
			next_out = `MEOG_ZERO;
		else if (ctrl_linear)
		begin
			if (lin_zero)
				next_out = `MEOG_ZERO;
			else if (alarm)
				next_out = lin_alarm;
			else
				next_out = ymap;
		end
		else if (relay_mode == MEOG_RM_DIS)
			next_out = `MEOG_ZERO;
		else
			next_out = next_on ? `MEOG_FULL : `MEOG_ZERO;
	end

	// Output registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			out_value <= `MEOG_ZERO;
			relay_high <= 1'b0;
		end
		else
		begin
			out_value <= next_out;
			relay_high <= relay_run && next_on;
		end
	end

	property p_rly_levels;
		!ctrl_linear |=> (out_value == `MEOG_FULL) || (out_value == `MEOG_ZERO);
	endproperty
	a_rly_levels: assert property (p_rly_levels) else $error("relay value not 0 or full");

	property p_rly_dis;
		out_active && !ctrl_linear && relay_mode == MEOG_RM_DIS |=> out_value == `MEOG_ZERO;
	endproperty
	a_rly_dis: assert property (p_rly_dis) else $error("disabled relay not zero");

	property p_hold;
		relay_run && hold |=> $stable(state) && $stable(delay_cnt) && $stable(hold_cnt);
	endproperty
	a_hold: assert property (p_hold) else $error("relay moved during held alarm");

	property p_imm;
		relay_run && (imm_on || imm_off) |=> relay_high == $past(imm_on)
			&& out_value == ($past(imm_on) ? `MEOG_FULL : `MEOG_ZERO);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate alarm not forced");

	property p_rise;
		relay_run && !imm_on && state == MEOG_ST_RISE ##1 state == MEOG_ST_HIGH
			|-> $past(delay_cnt) >= $past(on_delay) && $past(hold_cnt) >= $past(min_off);
	endproperty
	a_rise: assert property (p_rise) else $error("rose before delay or min low");

	property p_fall;
		relay_run && !imm_off && state == MEOG_ST_FALL ##1 state == MEOG_ST_LOW
			|-> $past(delay_cnt) >= $past(off_delay) && $past(hold_cnt) >= $past(min_on);
	endproperty
	a_fall: assert property (p_fall) else $error("fell before delay or min high");

	property p_no_jump;
		relay_run && !imm_on && state == MEOG_ST_LOW |=> state != MEOG_ST_HIGH;
	endproperty
	a_no_jump: assert property (p_no_jump) else $error("low to high without on-delay");

	property p_lin_alarm;
		out_active && ctrl_linear && !lin_zero && alarm |=> out_value == $past(lin_alarm);
	endproperty
	a_lin_alarm: assert property (p_lin_alarm) else $error("linear alarm value missing");

	property p_lin_zero;
		out_active && ctrl_linear && lin_zero |=> out_value == `MEOG_ZERO;
	endproperty
	a_lin_zero: assert property (p_lin_zero) else $error("undefined linear not zero");

	property p_lin_bounds;
		out_active && ctrl_linear && !lin_zero && !alarm
			|=> $signed({2'b00, out_value}) >= $past(omin)
			&& $signed({2'b00, out_value}) <= $past(omax);
	endproperty
	a_lin_bounds: assert property (p_lin_bounds) else $error("linear out of bounds");

endmodule

// ===== tb/meog_slave_model.sv
`include "meog_defs.svh"

// Far-side holding register, loaded with the value sent every cycle
module meog_slave_model
	import meog_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Written value and held register
	input wire logic [`MEOG_W-1:0] wr_value,
	output logic [`MEOG_W-1:0] reg_value
);
	timeunit 1ns;
	timeprecision 1ps;
	// Register keeps the last value written
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_value <= `MEOG_ZERO;
		else
			reg_value <= wr_value;
	end
endmodule

// ===== tb/test_meog_top.sv
`include "meog_defs.svh"

module test_meog_top
	import meog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, out_active, ctrl_linear, relay_high;
	logic signed [15:0] chan_value [0:59];
	logic [59:0] chan_defined, chan_error, below_range_flag, above_range_flag;
	logic [5:0] src_sel;
	meog_rmode_e relay_mode;
	meog_amode_e alarm_mode;
	logic signed [15:0] level, win_lower, win_upper, hyst, in_lo, in_hi;
	logic [15:0] on_delay, off_delay, min_on, min_off, out_lo, out_hi, lin_alarm;
	logic [15:0] out_value, reg_value;
	int fails, checks;
	// Short tick so delays stay a few clocks
	meog_top #(.TICK_CYC(4)) dut (.clk(clk), .rstn(rstn), .chan_value(chan_value),
		.chan_defined(chan_defined), .chan_error(chan_error),
		.below_range_flag(below_range_flag), .above_range_flag(above_range_flag),
		.out_active(out_active), .ctrl_linear(ctrl_linear), .src_sel(src_sel),
		.relay_mode(relay_mode), .alarm_mode(alarm_mode), .level(level),
		.win_lower(win_lower), .win_upper(win_upper), .hyst(hyst), .on_delay(on_delay),
		.off_delay(off_delay), .min_on(min_on), .min_off(min_off), .in_lo(in_lo),
		.in_hi(in_hi), .out_lo(out_lo), .out_hi(out_hi), .lin_alarm(lin_alarm),
		.out_value(out_value), .relay_high(relay_high));
	meog_slave_model slave (.clk(clk), .rstn(rstn), .wr_value(out_value),
		.reg_value(reg_value));
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic run(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic src(input logic signed [15:0] v, input int n);
		@(posedge clk);
		chan_value[3] <= v;
		run(n);
	endtask
	// Relay result as seen by the far side, plus the state flag
	task automatic chk_r(input logic [15:0] e);
		chk(reg_value, e);
		chk({16{relay_high}}, e);
	endtask
	task automatic t_levels();
		@(posedge clk);
		relay_mode <= MEOG_RM_ABOVE;
		src(11, 24); chk_r(16'h0000);
		src(13, 24); chk_r(16'hFFFF);
		src(9, 24); chk_r(16'hFFFF);
		src(7, 24); chk_r(16'h0000);
		@(posedge clk);
		relay_mode <= MEOG_RM_BELOW;
		src(9, 24); chk_r(16'h0000);
		src(7, 24); chk_r(16'hFFFF);
		src(13, 24); chk_r(16'h0000);
		@(posedge clk);
		relay_mode <= MEOG_RM_INSIDE;
		src(10, 24); chk_r(16'hFFFF);
		src(21, 24); chk_r(16'hFFFF);
		src(23, 24); chk_r(16'h0000);
		src(19, 24); chk_r(16'h0000);
		@(posedge clk);
		relay_mode <= MEOG_RM_OUTSIDE;
		src(-5, 24); chk_r(16'hFFFF);
		src(1, 24); chk_r(16'hFFFF);
		src(10, 24); chk_r(16'h0000);
		src(25, 24); chk_r(16'hFFFF);
		@(posedge clk);
		relay_mode <= MEOG_RM_DIS;
		run(24); chk(reg_value, 16'h0000);
	endtask
	task automatic t_timing();
		@(posedge clk);
		relay_mode <= MEOG_RM_ABOVE;
		on_delay <= 16'h0002;
		off_delay <= 16'h0002;
		src(0, 24); chk_r(16'h0000);
		src(13, 6); chk(out_value, 16'h0000);
		run(24); chk(out_value, 16'hFFFF);
		src(7, 6); chk(out_value, 16'hFFFF);
		run(24); chk(out_value, 16'h0000);
		@(posedge clk);
		on_delay <= 16'h0000;
		off_delay <= 16'h0000;
		min_on <= 16'h0008;
		src(13, 10); chk(out_value, 16'hFFFF);
		src(7, 6); chk(out_value, 16'hFFFF);
		run(40); chk(out_value, 16'h0000);
		@(posedge clk);
		min_on <= 16'h0000;
		min_off <= 16'h0008;
		// Look early: the low time began about thirty clocks ago
		src(13, 2); chk(out_value, 16'h0000);
		run(40); chk(out_value, 16'hFFFF);
		@(posedge clk);
		min_off <= 16'h0000;
		src(7, 24); chk(out_value, 16'h0000);
	endtask
	task automatic t_alarm();
		@(posedge clk);
		alarm_mode <= MEOG_AM_IMM_ON;
		chan_error[3] <= 1'b1;
		run(3); chk(out_value, 16'hFFFF);
		@(posedge clk);
		alarm_mode <= MEOG_AM_IMM_OFF;
		run(3); chk(out_value, 16'h0000);
		@(posedge clk);
		chan_error[3] <= 1'b0;
		src(13, 24); chk_r(16'hFFFF);
		@(posedge clk);
		alarm_mode <= MEOG_AM_HOLD;
		below_range_flag[3] <= 1'b1;
		src(7, 24); chk_r(16'hFFFF);
		@(posedge clk);
		below_range_flag[3] <= 1'b0;
		run(24); chk_r(16'h0000);
		@(posedge clk);
		on_delay <= 16'h0002;
		off_delay <= 16'h0002;
		alarm_mode <= MEOG_AM_TIM_ON;
		above_range_flag[3] <= 1'b1;
		run(4); chk(out_value, 16'h0000);
		run(24); chk(out_value, 16'hFFFF);
		@(posedge clk);
		alarm_mode <= MEOG_AM_TIM_OFF;
		run(4); chk(out_value, 16'hFFFF);
		run(24); chk(out_value, 16'h0000);
		@(posedge clk);
		above_range_flag[3] <= 1'b0;
	endtask
	task automatic t_linear();
		@(posedge clk);
		ctrl_linear <= 1'b1;
		src(150, 3); chk(out_value, 16'h09C4);
		src(0, 3); chk(out_value, 16'h03E8);
		src(-20, 3); chk(out_value, 16'h03E8);
		src(400, 3); chk(out_value, 16'h0FA0);
		// Inactive output sends zero although the map gives full range
		@(posedge clk);
		out_active <= 1'b0;
		run(3); chk(out_value, 16'h0000);
		@(posedge clk);
		out_active <= 1'b1;
		chan_error[3] <= 1'b1;
		run(3); chk(out_value, 16'h0123);
		@(posedge clk);
		chan_error[3] <= 1'b0;
		chan_value[59] <= 16'h012C;
		src_sel <= 6'h3B;
		run(3); chk(out_value, 16'h0FA0);
		@(posedge clk);
		src_sel <= 6'h3C;
		run(3); chk(out_value, 16'h0000);
		@(posedge clk);
		src_sel <= 6'h03;
		chan_defined[3] <= 1'b0;
		run(3); chk(out_value, 16'h0000);
		// Alarm kept on so a missed all-zero test would show the alarm value
		@(posedge clk);
		chan_defined[3] <= 1'b1;
		chan_error[3] <= 1'b1;
		{in_lo, in_hi, out_lo, out_hi} <= '0;
		run(3); chk(out_value, 16'h0000);
	endtask
	task automatic wrap_up();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		wrap_up();
	end
	// Setup, reset and scenarios
	initial
	begin
		fails = 0;
		checks = 0;
		rstn = 1'b0;
		foreach (chan_value[i]) chan_value[i] = '0;
		chan_defined = '1;
		{chan_error, below_range_flag, above_range_flag} = '0;
		out_active = 1'b1;
		ctrl_linear = 1'b0;
		src_sel = 6'h03;
		relay_mode = MEOG_RM_DIS;
		alarm_mode = MEOG_AM_HOLD;
		level = 10;
		hyst = 2;
		win_lower = 0;
		win_upper = 20;
		{on_delay, off_delay, min_on, min_off} = '0;
		in_lo = 0;
		in_hi = 300;
		out_lo = 16'h03E8;
		out_hi = 16'h0FA0;
		lin_alarm = 16'h0123;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		run(2); chk(out_value, 16'h0000);
		t_levels();
		t_timing();
		t_alarm();
		t_linear();
		wrap_up();
	end
endmodule
